// File: can_cmd_note_unused.sv
// Shared time unit for the interpreter sources; this file holds no logic.
`timescale 1ns/100ps

// File: can_cmd_parser.sv
// Response byte FIFO and the ASCII configuration command interpreter.
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Response FIFO
// ----------------------------------------------------------------
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} fifo_t;
	fifo_t f_reg;
	fifo_t f_next;
	logic  push;
	logic  pop;

	assign in_ready  = f_reg.cnt != (AW+1)'(DEPTH);
	assign out_valid = f_reg.cnt != '0;
	assign out_data  = f_reg.mem[f_reg.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		f_next = f_reg;
		if (push) begin
			f_next.mem[f_reg.wp] = in_data;
			f_next.wp = f_reg.wp + 1'b1;
		end
		if (pop)
			f_next.rp = f_reg.rp + 1'b1;
		if (push && !pop)
			f_next.cnt = f_reg.cnt + 1'b1;
		else if (pop && !push)
			f_next.cnt = f_reg.cnt - 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn)
			f_reg <= '0;
		else
			f_reg <= f_next;
	end
endmodule // byte_fifo

// Function
// RULE1: Unknown command letter answers bell only.
// RULE2: Received characters are never echoed.
// RULE3: Baud defaults 57.6k; chosen rate stored nonvolatile.
// RULE4: Frames accepted always, forwarded immediately.
// RULE5: H, h or ? sends command list.
// RULE6: Baud selector 0..8, independent of CAN.
// RULE7: Error LED flashes baud selector plus one.
// RULE8: Preset CAN rate selector 0..8, default 8.
// RULE9: Custom rate loads three timing bytes.
// RULE10: Channel returns to prior state after reconfiguration.
// RULE11: Mask takes three or eight hex digits.
// RULE12: Mask zero bits ignored, ones compared.
// RULE13: Masks default to all zeros.
// RULE14: Filter defaults 0x7FF and 0x1FFFFFFF.
// RULE15: Only matching frames forwarded, others dropped.
// RULE16: Host sends mask before filter.
// RULE17: Success answers CR, failure answers bell.
// RULE18: Bad parameters answer bell, settings unchanged.
// RULE19: Letters case sensitive, hex digits either case.
module can_cmd_parser
	import can_cmd_pkg::*;
#(
	parameter int FLASH_CYCLES = FLASH_CYCLES_DEF
) (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid,
	output logic             rx_ready,
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	input  wire logic [3:0]  nv_baud_sel,
	output logic             nv_baud_wr,
	output logic      [3:0]  baud_sel,
	output logic      [3:0]  can_rate_sel,
	output logic             rate_custom,
	output logic      [7:0]  bit_timing_cfg_first,
	output logic      [7:0]  bit_timing_cfg_second,
	output logic      [7:0]  bit_timing_cfg_third,
	input  wire logic        chan_open,
	output logic             chan_reconfig,
	output logic             chan_reopen,
	input  wire logic        soft_reset_req,
	input  wire logic        frame_valid,
	input  wire logic        frame_ext,
	input  wire logic [28:0] frame_id,
	output logic             frame_fwd,
	output logic             led_err_n
);
	localparam logic [25:0] FLASH_LAST = 26'(FLASH_CYCLES - 1);

	ctl_t       s_reg;
	ctl_t       s_next;
	logic       push_valid;
	logic       push_ready;
	logic [7:0] push_data;
	logic [4:0] hexd;
	logic       rx_take;
	logic       ok;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Hex digits decode in either case; result bit 4 flags a valid digit.
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= CH_DIG_0 && c <= CH_DIG_9)
			return {1'b1, 4'(c - CH_DIG_0)};
		else if (c >= CH_UP_A && c <= CH_UP_F)
			return {1'b1, 4'(c - CH_UP_A) + HEX_TEN};
		else if (c >= CH_LO_A && c <= CH_LO_F)
			return {1'b1, 4'(c - CH_LO_A) + HEX_TEN};
		else
			return 5'h00;
	endfunction

	function automatic logic id_match(input logic [28:0] id, input logic [28:0] filt,
			input logic [28:0] mask);
		return ((id ^ filt) & mask) == 29'h00000000; // [RULE12]
	endfunction

	function automatic logic cmd_known(input logic [7:0] c);
		return c == CH_HELP_UP || c == CH_HELP_LO || c == CH_HELP_QM || c == CH_BAUD ||
			c == CH_RATE_PRESET || c == CH_RATE_CUSTOM || c == CH_MASK || c == CH_FILTER;
	endfunction

	assign rx_ready   = s_reg.st == ST_CMD || s_reg.st == ST_PARAM;
	assign rx_take    = rx_valid && rx_ready;
	assign hexd       = hex_val(rx_data);
	// Only the two answering states feed the FIFO, so input never leaks out.
	assign push_valid = s_reg.st == ST_RESP || s_reg.st == ST_HELP; // [RULE2]
	assign push_data  = (s_reg.st == ST_HELP && s_reg.help_idx != HELP_END) ?
		HELP_TEXT[8*(HELP_LEN-1-int'(s_reg.help_idx)) +: 8] : s_reg.resp;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next          = s_reg;
		s_next.nv_wr    = 1'b0;
		s_next.reconfig = 1'b0;
		s_next.reopen   = 1'b0;
		ok              = 1'b0;
		// Forwarding runs in every state, independent of the parser.
		s_next.fwd = frame_valid && (frame_ext ? // [RULE4]
			id_match(frame_id, s_reg.filt_ext, s_reg.mask_ext) :
			id_match({18'h00000, frame_id[10:0]}, {18'h00000, s_reg.filt_std},
				{18'h00000, s_reg.mask_std})); // [RULE15]
		case (s_reg.st)
			ST_BOOT: begin
				// The stored selector is caught after the release of reset.
				s_next.baud_sel   = (nv_baud_sel <= SEL_MAX) ? nv_baud_sel : BAUD_DEFAULT; // [RULE3]
				s_next.flash_left = 4'((nv_baud_sel <= SEL_MAX ? nv_baud_sel : BAUD_DEFAULT) + 1'b1); // [RULE7]
				s_next.st         = ST_CMD;
			end
			ST_CMD: begin
				if (rx_take) begin
					s_next.cmd  = rx_data; // [RULE19]
					s_next.ndig = DIGITS_NONE;
					s_next.val  = '0;
					s_next.bad  = 1'b0;
					s_next.st   = (rx_data == CH_CR) ? ST_EXEC : ST_PARAM;
				end
			end
			ST_PARAM: begin
				if (rx_take) begin
					if (rx_data == CH_CR)
						s_next.st = ST_EXEC;
					else if (!hexd[4])
						s_next.bad = 1'b1; // [RULE18]
					else begin
						s_next.val = {s_reg.val[27:0], hexd[3:0]};
						if (s_reg.ndig != DIGITS_LIMIT)
							s_next.ndig = s_reg.ndig + 1'b1;
					end
				end
			end
			ST_EXEC: begin
				// Settings change only when the whole line is valid.
				if (!s_reg.bad) begin // [RULE18]
					case (s_reg.cmd)
						CH_HELP_UP, CH_HELP_LO, CH_HELP_QM: begin
							ok = s_reg.ndig == DIGITS_NONE; // [RULE5]
						end
						CH_BAUD: begin
							if (s_reg.ndig == DIGITS_SEL && s_reg.val[3:0] <= SEL_MAX) begin
								ok              = 1'b1;
								s_next.baud_sel = s_reg.val[3:0]; // [RULE6]
								s_next.nv_wr    = 1'b1; // [RULE3]
							end
						end
						CH_RATE_PRESET: begin
							if (s_reg.ndig == DIGITS_SEL && s_reg.val[3:0] <= SEL_MAX) begin
								ok              = 1'b1;
								s_next.rate_sel = s_reg.val[3:0]; // [RULE8]
								s_next.custom   = 1'b0;
							end
						end
						CH_RATE_CUSTOM: begin
							if (s_reg.ndig == DIGITS_CUSTOM) begin
								ok            = 1'b1;
								s_next.btc1   = s_reg.val[23:16]; // [RULE9]
								s_next.btc2   = s_reg.val[15:8];
								s_next.btc3   = s_reg.val[7:0];
								s_next.custom = 1'b1;
							end
						end
						CH_MASK, CH_FILTER: begin
							// Digit count picks the frame type.
							if (s_reg.ndig == DIGITS_STD && s_reg.val <= STD_ID_MAX) begin // [RULE11]
								ok = 1'b1;
								if (s_reg.cmd == CH_MASK)
									s_next.mask_std = s_reg.val[10:0];
								else
									s_next.filt_std = s_reg.val[10:0]; // [RULE14]
							end else if (s_reg.ndig == DIGITS_EXT && s_reg.val <= EXT_ID_MAX) begin
								ok = 1'b1;
								if (s_reg.cmd == CH_MASK)
									s_next.mask_ext = s_reg.val[28:0];
								else
									s_next.filt_ext = s_reg.val[28:0];
							end
						end
						default: ok = 1'b0; // [RULE1]
					endcase
				end
				if (ok && s_reg.cmd != CH_BAUD && !cmd_known(s_reg.cmd) == 1'b0 &&
						s_reg.cmd != CH_HELP_UP && s_reg.cmd != CH_HELP_LO &&
						s_reg.cmd != CH_HELP_QM) begin
					s_next.reconfig = 1'b1; // [RULE10]
					s_next.reopen   = chan_open;
				end
				s_next.resp     = ok ? CH_CR : CH_BELL; // [RULE17]
				s_next.help_idx = 5'h00;
				s_next.st       = (ok && s_reg.ndig == DIGITS_NONE && s_reg.cmd != CH_CR &&
					cmd_known(s_reg.cmd) && s_reg.cmd != CH_BAUD) ? ST_HELP : ST_RESP;
			end
			ST_RESP: begin
				if (push_ready)
					s_next.st = ST_CMD;
			end
			ST_HELP: begin
				if (push_ready) begin
					if (s_reg.help_idx == HELP_END)
						s_next.st = ST_CMD;
					else
						s_next.help_idx = s_reg.help_idx + 1'b1;
				end
			end
			default: s_next.st = ST_CMD;
		endcase
		// Flash code: one on period plus one off period per count.
		if (soft_reset_req)
			s_next.flash_left = 4'(s_reg.baud_sel + 1'b1); // [RULE7]
		if (s_reg.flash_left != 4'h0 && s_reg.st != ST_BOOT && !soft_reset_req) begin
			if (s_reg.flash_tmr == FLASH_LAST) begin
				s_next.flash_tmr = '0;
				s_next.flash_on  = !s_reg.flash_on;
				if (s_reg.flash_on)
					s_next.flash_left = s_reg.flash_left - 1'b1;
			end else
				s_next.flash_tmr = s_reg.flash_tmr + 1'b1;
		end
		if (soft_reset_req) begin
			s_next.flash_tmr = '0;
			s_next.flash_on  = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_reg          <= '0;
			s_reg.st       <= ST_BOOT;
			s_reg.baud_sel <= BAUD_DEFAULT; // [RULE3]
			s_reg.rate_sel <= CAN_RATE_DEFAULT; // [RULE8]
			s_reg.mask_std <= MASK_STD_DEFAULT; // [RULE13]
			s_reg.mask_ext <= MASK_EXT_DEFAULT;
			s_reg.filt_std <= FILT_STD_DEFAULT; // [RULE14]
			s_reg.filt_ext <= FILT_EXT_DEFAULT;
		end else
			s_reg <= s_next;
	end

	// ----------------------------------------------------------------
	// Outputs and response buffer
	// ----------------------------------------------------------------
	assign nv_baud_wr            = s_reg.nv_wr;
	assign baud_sel              = s_reg.baud_sel;
	assign can_rate_sel          = s_reg.rate_sel;
	assign rate_custom           = s_reg.custom;
	assign bit_timing_cfg_first  = s_reg.btc1;
	assign bit_timing_cfg_second = s_reg.btc2;
	assign bit_timing_cfg_third  = s_reg.btc3;
	assign chan_reconfig         = s_reg.reconfig;
	assign chan_reopen           = s_reg.reopen;
	assign frame_fwd             = s_reg.fwd;
	assign led_err_n             = !s_reg.flash_on;

	// A full buffer stalls the answer, which in turn holds rx_ready low.
	byte_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) resp_fifo (
		.clk_sys   (clk_sys),
		.resetn    (resetn),
		.in_data   (push_data),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.out_data  (tx_data),
		.out_valid (tx_valid),
		.out_ready (tx_ready)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	bell_unknown_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE1]
		(s_reg.st == ST_EXEC && !cmd_known(s_reg.cmd)) |=>
		(s_reg.st == ST_RESP && s_reg.resp == CH_BELL && !s_reg.reconfig && !s_reg.nv_wr))
		else $error("unknown command not answered by bell");
	no_echo_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE2]
		rx_take |=> !push_valid)
		else $error("character pushed right after reception");
	nv_store_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE3]
		nv_baud_wr |-> ($past(s_reg.cmd) == CH_BAUD && baud_sel == $past(s_reg.val[3:0])))
		else $error("baud store without baud command");
	help_end_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE5]
		(s_reg.st == ST_HELP && s_reg.help_idx == HELP_END && push_ready) |=> s_reg.st == ST_CMD)
		else $error("help list not closed");
	flash_count_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE7]
		$rose(s_reg.flash_left != 4'h0) |-> s_reg.flash_left == 4'(s_reg.baud_sel + 1'b1))
		else $error("flash count differs from baud selector plus one");
	rate_change_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE8]
		$changed(can_rate_sel) |-> ($past(s_reg.st) == ST_EXEC && can_rate_sel <= SEL_MAX))
		else $error("CAN rate changed outside preset command");
	reopen_only_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE10]
		chan_reopen |-> (chan_reconfig && $past(chan_open)))
		else $error("reopen without prior open channel");
	filter_drop_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE15]
		(frame_valid && !frame_ext && ((frame_id[10:0] ^ s_reg.filt_std) & s_reg.mask_std) != 11'h000)
		|=> !frame_fwd)
		else $error("non matching standard frame forwarded");
	bad_param_a: assert property (@(posedge clk_sys) disable iff (!resetn) // [RULE18]
		(s_reg.st == ST_EXEC && s_reg.bad) |=> (s_reg.resp == CH_BELL && $stable(s_reg.mask_std)))
		else $error("bad parameter accepted");
endmodule // can_cmd_parser
`default_nettype wire

// File: can_cmd_pkg.sv
// Constants, encodings and state layout of the serial command interpreter.
`default_nettype none
package can_cmd_pkg;
	// ----------------------------------------------------------------
	// Characters
	// ----------------------------------------------------------------
	localparam logic [7:0] CH_BELL        = 8'h07;
	localparam logic [7:0] CH_CR          = 8'h0d;
	localparam logic [7:0] CH_HELP_QM     = 8'h3f;
	localparam logic [7:0] CH_HELP_UP     = 8'h48;
	localparam logic [7:0] CH_HELP_LO     = 8'h68;
	localparam logic [7:0] CH_BAUD        = 8'h55;
	localparam logic [7:0] CH_RATE_PRESET = 8'h53;
	localparam logic [7:0] CH_RATE_CUSTOM = 8'h73;
	localparam logic [7:0] CH_MASK        = 8'h6d;
	localparam logic [7:0] CH_FILTER      = 8'h4d;
	localparam logic [7:0] CH_DIG_0       = 8'h30;
	localparam logic [7:0] CH_DIG_9       = 8'h39;
	localparam logic [7:0] CH_UP_A        = 8'h41;
	localparam logic [7:0] CH_UP_F        = 8'h46;
	localparam logic [7:0] CH_LO_A        = 8'h61;
	localparam logic [7:0] CH_LO_F        = 8'h66;
	localparam logic [3:0] HEX_TEN        = 4'ha;

	// ----------------------------------------------------------------
	// Parameter limits and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0]  SEL_MAX          = 4'h8;
	localparam logic [3:0]  BAUD_DEFAULT     = 4'h2;
	localparam logic [3:0]  CAN_RATE_DEFAULT = 4'h8;
	localparam logic [3:0]  DIGITS_NONE      = 4'h0;
	localparam logic [3:0]  DIGITS_SEL       = 4'h1;
	localparam logic [3:0]  DIGITS_STD       = 4'h3;
	localparam logic [3:0]  DIGITS_CUSTOM    = 4'h6;
	localparam logic [3:0]  DIGITS_EXT       = 4'h8;
	localparam logic [3:0]  DIGITS_LIMIT     = 4'h9;
	localparam logic [31:0] STD_ID_MAX       = 32'h000007ff;
	localparam logic [31:0] EXT_ID_MAX       = 32'h1fffffff;
	localparam logic [10:0] MASK_STD_DEFAULT = 11'h000;
	localparam logic [28:0] MASK_EXT_DEFAULT = 29'h00000000;
	localparam logic [10:0] FILT_STD_DEFAULT = 11'h7ff;
	localparam logic [28:0] FILT_EXT_DEFAULT = 29'h1fffffff;
	localparam int          CAN_CTRL_CLK_HZ  = 24_000_000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 5;
	localparam int FLASH_MS         = 200;
	localparam int FLASH_CYCLES_DEF = FLASH_MS * 1_000_000 / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Help text and buffer
	// ----------------------------------------------------------------
	localparam int             HELP_LEN  = 20;
	localparam logic [159:0]   HELP_TEXT = "OCtTFVNZSsmMBLERUH?h";
	localparam logic [4:0]     HELP_END  = 5'h14;
	localparam int             FIFO_W    = 8;
	localparam int             FIFO_D    = 32;

	typedef enum logic [2:0] {
		ST_BOOT  = 3'b000,
		ST_CMD   = 3'b001,
		ST_PARAM = 3'b010,
		ST_EXEC  = 3'b011,
		ST_RESP  = 3'b100,
		ST_HELP  = 3'b101
	} st_t;

	typedef struct packed {
		st_t         st;
		logic [7:0]  cmd;
		logic [3:0]  ndig;
		logic [31:0] val;
		logic        bad;
		logic [7:0]  resp;
		logic [4:0]  help_idx;
		logic [3:0]  baud_sel;
		logic        nv_wr;
		logic [3:0]  rate_sel;
		logic        custom;
		logic [7:0]  btc1;
		logic [7:0]  btc2;
		logic [7:0]  btc3;
		logic [10:0] mask_std;
		logic [10:0] filt_std;
		logic [28:0] mask_ext;
		logic [28:0] filt_ext;
		logic        reconfig;
		logic        reopen;
		logic        fwd;
		logic [3:0]  flash_left;
		logic        flash_on;
		logic [25:0] flash_tmr;
	} ctl_t;
endpackage
`default_nettype wire

// File: host_model.sv
// Host terminal model: sends command lines and collects the answers.
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input  wire logic       clk_sys,
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	input  wire logic       rx_ready,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	logic [7:0] got_q[$];
	int         stall;
	int         cyc;
	logic       hung;

	initial begin
		rx_data  = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
		stall    = 0;
		cyc      = 0;
		hung     = 1'b0;
	end

	// Stall 1 is ready for two cycles in every four, stall 2 takes none.
	always @(negedge clk_sys) begin
		cyc++;
		tx_ready <= (stall == 0) || (stall == 1 && cyc[1]);
	end

	always @(posedge clk_sys) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			got_q.push_back(tx_data);
	end

	task automatic send_byte(input logic [7:0] b);
		int n;
		n = 0;
		@(negedge clk_sys);
		rx_data  <= b;
		rx_valid <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (rx_ready !== 1'b1 && n < 500);
		if (rx_ready !== 1'b1)
			hung = 1'b1;
	endtask

	// The released data line shows the inverse so a stale byte never passes.
	task automatic send_line(input string s);
		for (int i = 0; i < s.len(); i++)
			send_byte(s[i]);
		send_byte(8'h0d);
		@(negedge clk_sys);
		rx_valid <= 1'b0;
		rx_data  <= ~rx_data;
	endtask
endmodule // host_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the serial command interpreter.
`timescale 1ns/100ps
`default_nettype none
module testbench
	import can_cmd_pkg::*;
;
	// ------------
	// Signals
	// ------------
	localparam int    FC   = 8;
	localparam string OK   = "\015";
	localparam string BELL = "\007";
	localparam string HELP = "OCtTFVNZSsmMBLERUH?h\015";
	logic        clk_sys, resetn, rx_valid, rx_ready, tx_valid, tx_ready;
	logic [7:0]  rx_data, tx_data, btc1, btc2, btc3;
	logic [3:0]  nv_baud_sel, baud_sel, can_rate_sel;
	logic        nv_baud_wr, rate_custom, chan_open, chan_reconfig, chan_reopen;
	logic        soft_reset_req, frame_valid, frame_ext, frame_fwd, led_err_n;
	logic [28:0] frame_id;
	int          fails, total_checks, n_nvwr, n_recfg, n_reopen, n_flash;

	can_cmd_parser #(.FLASH_CYCLES(FC)) can_cmd_parser_inst (
		.clk_sys(clk_sys), .resetn(resetn),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.nv_baud_sel(nv_baud_sel), .nv_baud_wr(nv_baud_wr), .baud_sel(baud_sel),
		.can_rate_sel(can_rate_sel), .rate_custom(rate_custom),
		.bit_timing_cfg_first(btc1), .bit_timing_cfg_second(btc2),
		.bit_timing_cfg_third(btc3), .chan_open(chan_open),
		.chan_reconfig(chan_reconfig), .chan_reopen(chan_reopen),
		.soft_reset_req(soft_reset_req), .frame_valid(frame_valid),
		.frame_ext(frame_ext), .frame_id(frame_id), .frame_fwd(frame_fwd),
		.led_err_n(led_err_n)
	);

	host_model host_model_inst (
		.clk_sys(clk_sys), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready)
	);

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		if (nv_baud_wr === 1'b1)
			n_nvwr++;
		if (chan_reconfig === 1'b1)
			n_recfg++;
		if (chan_reopen === 1'b1)
			n_reopen++;
	end

	always @(negedge led_err_n)
		n_flash++;

	// ------------
	// Checking tasks
	// ------------
	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Waiting a few cycles past the expected length catches stray or echoed bytes.
	task automatic check_resp(input string what, input string exp);
		int n;
		n = 0;
		while (host_model_inst.got_q.size() < exp.len() && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		check_val({what, " length"}, exp.len(), host_model_inst.got_q.size());
		for (int i = 0; i < exp.len() && i < host_model_inst.got_q.size(); i++)
			check_val(what, exp[i], host_model_inst.got_q[i]);
		host_model_inst.got_q.delete();
	endtask

	task automatic cmd(input string s, input string exp);
		host_model_inst.send_line(s);
		check_resp(s, exp);
	endtask

	function automatic string sel(input logic [7:0] c, input int d);
		string s;
		s = "00";
		s[0] = c;
		s[1] = 8'(CH_DIG_0 + d);
		return s;
	endfunction

	task automatic frame(input logic ext, input logic [28:0] id, input logic exp);
		@(negedge clk_sys);
		frame_ext   <= ext;
		frame_id    <= id;
		frame_valid <= 1'b1;
		@(negedge clk_sys);
		frame_valid <= 1'b0;
		frame_id    <= ~id;
		check_val("frame forward", exp, frame_fwd);
	endtask

	// ------------
	// Scenarios
	// ------------
	task automatic t_boot();
		check_val("boot baud", 4'h5, baud_sel);
		check_val("boot rate", 4'h8, can_rate_sel);
		frame(1'b0, 29'h123, 1'b1);
		frame(1'b1, 29'h0abcdef0, 1'b1);
		repeat (200) @(posedge clk_sys);
		check_val("boot flashes", 6, n_flash);
	endtask

	task automatic t_help();
		cmd("?", HELP);
		cmd("H", HELP);
		cmd("h", HELP);
		cmd("H1", BELL);
		cmd("O", BELL);
		cmd("X", BELL);
		cmd("", BELL);
	endtask

	task automatic t_baud();
		int w;
		w = n_nvwr;
		host_model_inst.stall = 1;
		for (int d = 0; d <= SEL_MAX; d++) begin
			cmd(sel(CH_BAUD, d), OK);
			check_val("baud select", d, baud_sel);
		end
		check_val("store writes", w + 9, n_nvwr);
		cmd("U9", BELL);
		cmd("u5", BELL);
		check_val("baud kept", 4'h8, baud_sel);
		host_model_inst.stall = 0;
		n_flash = 0;
		@(negedge clk_sys);
		soft_reset_req <= 1'b1;
		@(negedge clk_sys);
		soft_reset_req <= 1'b0;
		repeat (250) @(posedge clk_sys);
		check_val("reset flashes", 9, n_flash);
	endtask

	task automatic t_rate();
		int r;
		int o;
		r = n_recfg;
		o = n_reopen;
		@(negedge clk_sys);
		chan_open <= 1'b1;
		for (int d = 0; d <= SEL_MAX; d++) begin
			cmd(sel(CH_RATE_PRESET, d), OK);
			check_val("preset rate", d, can_rate_sel);
		end
		check_val("reconfig count", r + 9, n_recfg);
		check_val("reopen count", o + 9, n_reopen);
		@(negedge clk_sys);
		chan_open <= 1'b0;
		cmd("S3", OK);
		check_val("closed reconfig", r + 10, n_recfg);
		check_val("closed reopen", o + 9, n_reopen);
		cmd("S9", BELL);
		check_val("rate kept", 4'h3, can_rate_sel);
		cmd("s01be07", OK);
		check_val("timing first", 8'h01, btc1);
		check_val("timing second", 8'hbe, btc2);
		check_val("timing third", 8'h07, btc3);
		check_val("custom on", 1'b1, rate_custom);
		cmd("s01BE0", BELL);
		cmd("s01BG07", BELL);
		check_val("timing kept", 8'hbe, btc2);
		cmd("S8", OK);
		check_val("custom off", 1'b0, rate_custom);
	endtask

	task automatic t_filter();
		cmd("m7FF", OK);
		frame(1'b0, 29'h7ff, 1'b1);
		frame(1'b0, 29'h7fe, 1'b0);
		cmd("m700", OK);
		cmd("M1FF", OK);
		frame(1'b0, 29'h1a5, 1'b1);
		frame(1'b0, 29'h2ff, 1'b0);
		cmd("m1FFFFFFF", OK);
		frame(1'b1, 29'h1fffffff, 1'b1);
		frame(1'b1, 29'h1ffffffe, 1'b0);
		cmd("m1fffff00", OK);
		cmd("M12345600", OK);
		frame(1'b1, 29'h12345677, 1'b1);
		frame(1'b1, 29'h12355600, 1'b0);
		cmd("m800", BELL);
		cmd("m7ff0", BELL);
		cmd("M2FFFFFFF", BELL);
		frame(1'b0, 29'h1a5, 1'b1);
		frame(1'b0, 29'h2ff, 1'b0);
	endtask

	// A mid-run reset with a blank store must fall back to the factory rate.
	task automatic t_reset();
		@(negedge clk_sys);
		resetn      <= 1'b0;
		nv_baud_sel <= 4'hf;
		repeat (3) @(negedge clk_sys);
		n_flash = 0;
		resetn <= 1'b1;
		repeat (3) @(negedge clk_sys);
		check_val("factory baud", 4'h2, baud_sel);
		check_val("factory rate", 4'h8, can_rate_sel);
		frame(1'b0, 29'h2ff, 1'b1);
		frame(1'b1, 29'h12355600, 1'b1);
		repeat (100) @(posedge clk_sys);
		check_val("factory flashes", 3, n_flash);
	endtask

	// The answer buffer is filled until it refuses, then drained whole.
	task automatic t_fifo();
		host_model_inst.stall = 2;
		host_model_inst.send_line("?");
		host_model_inst.send_line("h");
		repeat (60) @(posedge clk_sys);
		@(negedge clk_sys);
		check_val("answer waiting", 1'b1, tx_valid);
		check_val("input refused", 1'b0, rx_ready);
		host_model_inst.stall = 0;
		check_resp("double help", {HELP, HELP});
	endtask

	task automatic report_and_stop();
		check_val("host hang", 1'b0, host_model_inst.hung);
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ------------
	// Main sequence
	// ------------
	initial begin
		fails          = 0;
		total_checks   = 0;
		n_nvwr         = 0;
		n_recfg        = 0;
		n_reopen       = 0;
		n_flash        = 0;
		resetn         = 1'b0;
		nv_baud_sel    = 4'h5;
		chan_open      = 1'b0;
		soft_reset_req = 1'b0;
		frame_valid    = 1'b0;
		frame_ext      = 1'b0;
		frame_id       = 29'h0;
		repeat (20) @(posedge clk_sys);
		@(negedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(negedge clk_sys);
		t_boot();
		t_help();
		t_baud();
		t_rate();
		t_filter();
		t_reset();
		t_fifo();
		report_and_stop();
	end

	initial begin
		repeat (40000) @(posedge clk_sys);
		fails++;
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
